// ===== rtl/rps_top.v
// Remappable pin select: APB registers, input and output routing
`timescale 1ns/1ps
`include "rps_map.vh"
// Notes on behaviour
// RQ1 - Input code n routes pin n to 25
// RQ2 - Input code all ones ties input low
// RQ3 - Input selectors reset to all ones
// RQ4 - Output selectors reset to zero
// RQ5 - Unfielded bits always read as zero
// RQ6 - UART register: CTS bits 12-8, RX 4-0
// RQ7 - SPI register: clock 12-8, data 4-0
// RQ8 - SPI select register: bits 4-0 only
// RQ9 - Output register: even pin low, odd high
// RQ10 - Function 3 is UART TX, 4 RTS
// RQ11 - Writes need 0x46,0x57 unlock, lock bit clear
// RQ12 - Function zero leaves pin to port
module rps_top
#(
  parameter PINS     = 26,
  parameter OUT_PINS = 10
)
(
  input  wire                   clk_sys,
  input  wire                   reset,
  input  wire                   clk_en,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`RPS_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  input  wire [PINS-1:0]        remappable_pin,
  input  wire                   uart_transmit_out,
  input  wire                   uart_rts_out,
  input  wire [OUT_PINS-1:0]    port_out,
  output reg  [OUT_PINS-1:0]    pin_out,
  output reg  [OUT_PINS-1:0]    pin_out_en,
  output reg                    uart_receive_in,
  output reg                    uart_clear_to_send_in,
  output reg                    spi_clock_in,
  output reg                    spi_data_in,
  output reg                    spi_slave_select_in,
  output reg                    selectors_locked
);
  // Input selector fields
  reg  [`RPS_FLD_W-1:0] uart_cts_pin_choice;
  reg  [`RPS_FLD_W-1:0] uart_rx_pin_choice;
  reg  [`RPS_FLD_W-1:0] spi_clock_pin_choice;
  reg  [`RPS_FLD_W-1:0] spi_data_in_pin_choice;
  reg  [`RPS_FLD_W-1:0] spi_select_pin_choice;
  // Output function fields, one per pin, indexed
  reg  [`RPS_FLD_W-1:0] pin_output_function [0:OUT_PINS-1];
  // Unlock sequence state
  reg  [1:0]            key_state;
  reg                   lock;
  // Combinational routing results
  wire                  rx_sel;
  wire                  cts_sel;
  wire                  sck_sel;
  wire                  sdi_sel;
  wire                  ss_sel;
  wire [OUT_PINS-1:0]   fn_val;
  wire [OUT_PINS-1:0]   fn_en;
  // Decode helpers
  wire                  access;
  wire                  wr;
  wire [`RPS_ADDR_W-3:0] word_idx;
  wire                  out_hit;
  wire [`RPS_ADDR_W-3:0] out_pair;
  reg  [31:0]           next_rdata;
  reg                   next_err;
  integer               i;                 // Reset loop index

  // Key sequencer states; any stray write without an error falls back to idle
  localparam KEY_IDLE = 2'b00; // Waiting for the first key byte
  localparam KEY_ONE  = 2'b01; // First key byte seen
  localparam KEY_OPEN = 2'b10; // Both keys seen, next write moves lock

  // Word index of the first pair register, held at the index width
  localparam [`RPS_ADDR_W-3:0] OUT_BASE = `RPS_OUT_BASE_IDX;

  // Bus decode
  // Access is the first access-phase cycle only: pready high blocks a
  // second take of the same transfer while the master still holds it
  assign access   = psel && penable && !pready;
  assign wr       = access && pwrite;
  // Registers sit on aligned words, so the two low address bits drop
  assign word_idx = paddr[`RPS_ADDR_W-1:2];
  // Pair number of an output register; only meaningful under out_hit
  assign out_pair = word_idx - OUT_BASE;
  // Pair registers are the aligned words from the first to the last pair
  assign out_hit  = (paddr >= `RPS_OFF_OUT_0_1) &&
                    (paddr <= `RPS_OFF_OUT_8_9) && (paddr[1:0] == 2'b00);

  // Input routing, one selector per peripheral input
  // Selection is combinational; the output process registers it
  // UART receive data
  rps_in_select #(.PINS(PINS)) u_rx
  (
    .pins    (remappable_pin),
    .choice  (uart_rx_pin_choice),
    .sel_out (rx_sel)
  );
  // UART clear to send
  rps_in_select #(.PINS(PINS)) u_cts
  (
    .pins    (remappable_pin),
    .choice  (uart_cts_pin_choice),
    .sel_out (cts_sel)
  );
  // SPI serial clock
  rps_in_select #(.PINS(PINS)) u_sck
  (
    .pins    (remappable_pin),
    .choice  (spi_clock_pin_choice),
    .sel_out (sck_sel)
  );
  // SPI serial data in
  rps_in_select #(.PINS(PINS)) u_sdi
  (
    .pins    (remappable_pin),
    .choice  (spi_data_in_pin_choice),
    .sel_out (sdi_sel)
  );
  // SPI slave select
  rps_in_select #(.PINS(PINS)) u_ss
  (
    .pins    (remappable_pin),
    .choice  (spi_select_pin_choice),
    .sel_out (ss_sel)
  );

  // Output routing per pin
  // One decoder per pin; the register stage sits in the output process
  genvar g;
  generate
    for (g = 0; g < OUT_PINS; g = g + 1)
    begin : g_out
      // All pins share the same two peripheral sources
      rps_out_select u_osel
      (
        .func     (pin_output_function[g]),
        .uart_tx  (uart_transmit_out),
        .uart_rts (uart_rts_out),
        .pin_val  (fn_val[g]),
        .pin_en   (fn_en[g])
      );
    end
  endgenerate

  // Read mux; unfielded bits stay zero
  // Decoded every cycle; only a taken read copies it to prdata
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    // Pair register: even pin in the low field, odd pin in the high
    if (out_hit)
    begin
      next_rdata[`RPS_LO_LSB +: `RPS_FLD_W] = pin_output_function[2*out_pair]; // RQ9
      next_rdata[`RPS_HI_LSB +: `RPS_FLD_W] = pin_output_function[2*out_pair+1]; // RQ9
    end
    else
    begin
      // Selector registers and lock status by exact byte address
      case (paddr)
        `RPS_OFF_UART_IN:
        begin
          next_rdata[`RPS_HI_LSB +: `RPS_FLD_W] = uart_cts_pin_choice; // RQ6
          next_rdata[`RPS_LO_LSB +: `RPS_FLD_W] = uart_rx_pin_choice; // RQ6
        end
        `RPS_OFF_SPI_CD_IN:
        begin
          next_rdata[`RPS_HI_LSB +: `RPS_FLD_W] = spi_clock_pin_choice; // RQ7
          next_rdata[`RPS_LO_LSB +: `RPS_FLD_W] = spi_data_in_pin_choice; // RQ7
        end
        `RPS_OFF_SPI_SS_IN:
          next_rdata[`RPS_LO_LSB +: `RPS_FLD_W] = spi_select_pin_choice; // RQ8
        // Lock status and oscillator low byte both show the lock bit
        `RPS_OFF_LOCK:
          next_rdata[`RPS_LOCK_BIT] = lock;
        `RPS_OFF_OSC_LOW:
          next_rdata[`RPS_LOCK_BIT] = lock;
        // Anything else is unmapped and answers with an error
        default:
          next_err = 1'b1;
      endcase
    end
  end // RQ5

  // Registers, unlock sequence and APB answer
  // A write lands on the take edge, the same edge that raises pready
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      // Peripheral inputs start tied low, pins start unassigned
      uart_cts_pin_choice    <= `RPS_IN_RESET; // RQ3
      uart_rx_pin_choice     <= `RPS_IN_RESET; // RQ3
      spi_clock_pin_choice   <= `RPS_IN_RESET; // RQ3
      spi_data_in_pin_choice <= `RPS_IN_RESET; // RQ3
      spi_select_pin_choice  <= `RPS_IN_RESET; // RQ3
      for (i = 0; i < OUT_PINS; i = i + 1)
        pin_output_function[i] <= `RPS_OUT_RESET; // RQ4
      // Lock starts set, so selectors need the key sequence first
      key_state <= KEY_IDLE;
      lock      <= 1'b1;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end
    else if (clk_en)
    begin
      // One wait state: pready rises one cycle into the access phase
      pready  <= access;
      pslverr <= access ? next_err : 1'b0;
      prdata  <= (access && !pwrite) ? next_rdata : 32'h0000_0000;
      // Errored writes change nothing, not even the key sequencer
      if (wr && !next_err)
      begin
        if (paddr == `RPS_OFF_OSC_LOW)
        begin
          // Key bytes arrive in the low byte; lock bit moves only once open
          case (key_state)
            KEY_IDLE:
              key_state <= (pwdata[7:0] == `RPS_KEY1) ? KEY_ONE : KEY_IDLE; // RQ11
            KEY_ONE:
              key_state <= (pwdata[7:0] == `RPS_KEY2) ? KEY_OPEN : KEY_IDLE; // RQ11
            KEY_OPEN:
            begin
              lock      <= pwdata[`RPS_LOCK_BIT]; // RQ11
              key_state <= KEY_IDLE;
            end
            default:
              key_state <= KEY_IDLE;
          endcase
        end
        else
        begin
          // Any other write breaks a half-entered key sequence
          key_state <= KEY_IDLE;
          // Locked selectors ignore writes silently
          if (!lock)
          begin
            // Both fields of a pair register move together
            if (out_hit)
            begin
              pin_output_function[2*out_pair] <= pwdata[`RPS_LO_LSB +: `RPS_FLD_W]; // RQ9
              pin_output_function[2*out_pair+1] <= pwdata[`RPS_HI_LSB +: `RPS_FLD_W]; // RQ9
            end
            else if (paddr == `RPS_OFF_UART_IN)
            begin
              uart_cts_pin_choice <= pwdata[`RPS_HI_LSB +: `RPS_FLD_W]; // RQ6
              uart_rx_pin_choice  <= pwdata[`RPS_LO_LSB +: `RPS_FLD_W]; // RQ6
            end
            else if (paddr == `RPS_OFF_SPI_CD_IN)
            begin
              spi_clock_pin_choice   <= pwdata[`RPS_HI_LSB +: `RPS_FLD_W]; // RQ7
              spi_data_in_pin_choice <= pwdata[`RPS_LO_LSB +: `RPS_FLD_W]; // RQ7
            end
            else if (paddr == `RPS_OFF_SPI_SS_IN)
              spi_select_pin_choice <= pwdata[`RPS_LO_LSB +: `RPS_FLD_W]; // RQ8
          end
        end
      end
    end
  end

  // Registered outputs toward peripherals and pads
  // Registering every output keeps pad and peripheral timing clean
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      // Nothing driven and every peripheral input low during reset
      pin_out               <= {OUT_PINS{1'b0}};
      pin_out_en            <= {OUT_PINS{1'b0}};
      uart_receive_in       <= 1'b0;
      uart_clear_to_send_in <= 1'b0;
      spi_clock_in          <= 1'b0;
      spi_data_in           <= 1'b0;
      spi_slave_select_in   <= 1'b0;
      selectors_locked      <= 1'b1;
    end
    else if (clk_en)
    begin
      // Function zero falls back to the port latch value
      pin_out    <= (fn_val & fn_en) | (port_out & ~fn_en); // RQ12
      // Enable follows the decode, so function zero releases the pin
      pin_out_en <= fn_en;
      // Peripheral inputs lag the pins by this one register stage
      uart_receive_in       <= rx_sel;
      uart_clear_to_send_in <= cts_sel;
      spi_clock_in          <= sck_sel;
      spi_data_in           <= sdi_sel;
      spi_slave_select_in   <= ss_sel;
      // Lock status mirrors the lock bit one cycle late
      selectors_locked      <= lock;
    end
  end
endmodule // rps_top

// ===== pkg/rps_map.vh
// Register map, field layout and function codes of the pin select block
`ifndef RPS_MAP_VH
`define RPS_MAP_VH
`define RPS_OFF_UART_IN   12'h000
`define RPS_OFF_SPI_CD_IN 12'h004
`define RPS_OFF_SPI_SS_IN 12'h008
`define RPS_OFF_OUT_0_1   12'h00C
`define RPS_OFF_OUT_2_3   12'h010
`define RPS_OFF_OUT_4_5   12'h014
`define RPS_OFF_OUT_6_7   12'h018
`define RPS_OFF_OUT_8_9   12'h01C
`define RPS_OFF_LOCK      12'h020
`define RPS_OFF_OSC_LOW   12'h024
`define RPS_OUT_BASE_IDX  3
`define RPS_FLD_W         5
`define RPS_LO_LSB        0
`define RPS_HI_LSB        8
`define RPS_IN_RESET      5'h1F
`define RPS_IN_GROUND     5'h1F
`define RPS_OUT_RESET     5'h00
`define RPS_FN_NONE       5'h00
`define RPS_FN_UART_TX    5'h03
`define RPS_FN_UART_RTS   5'h04
`define RPS_KEY1          8'h46
`define RPS_KEY2          8'h57
`define RPS_LOCK_BIT      6
`define RPS_ADDR_W        12
`endif

// ===== rtl/rps_in_select.v
// One input selector: remappable pin or ground onto a peripheral input
`timescale 1ns/1ps
`include "rps_map.vh"
module rps_in_select
#(
  parameter PINS = 26
)
(
  input  wire [PINS-1:0]           pins,
  input  wire [`RPS_FLD_W-1:0]     choice,
  output reg                       sel_out
);
  // Codes past the last pin (including ground code) give low
  always @*
  begin
    if (choice == `RPS_IN_GROUND)
      sel_out = 1'b0; // RQ2
    else if (choice < PINS)
      sel_out = pins[choice]; // RQ1
    else
      sel_out = 1'b0;
  end
endmodule // rps_in_select

// ===== rtl/rps_out_select.v
// One output selector: function number picks what drives a pin
`timescale 1ns/1ps
`include "rps_map.vh"
module rps_out_select
(
  input  wire [`RPS_FLD_W-1:0] func,
  input  wire                  uart_tx,
  input  wire                  uart_rts,
  output reg                   pin_val,
  output reg                   pin_en
);
  // Unknown numbers drive nothing rather than a guessed source
  always @*
  begin
    pin_val = 1'b0;
    pin_en  = 1'b0; // RQ12
    case (func)
      `RPS_FN_UART_TX:
      begin
        pin_val = uart_tx; // RQ10
        pin_en  = 1'b1;
      end
      `RPS_FN_UART_RTS:
      begin
        pin_val = uart_rts; // RQ10
        pin_en  = 1'b1;
      end
      default:
      begin
        pin_val = 1'b0;
        pin_en  = 1'b0;
      end
    endcase
  end
endmodule // rps_out_select

// ===== bench/rps_periph.sv
// Partner model: remappable pins, UART outputs and port values
`timescale 1ns/1ps
module rps_periph
(
  input  wire        clk_sys,
  input  wire [31:0] seed_v,
  output reg  [25:0] pins   = 26'h0,
  output reg         tx     = 1'h0,
  output reg         rts    = 1'h0,
  output reg  [9:0]  port_v = 10'h0
);
  // Levels move only at an edge, so the bench knows what was sampled
  always @(posedge clk_sys)
  begin
    pins   <= seed_v[25:0];
    tx     <= seed_v[26];
    rts    <= seed_v[27];
    port_v <= seed_v[31:22];
  end
endmodule // rps_periph

// ===== bench/rps_sva.sv
// Port checker of the pin select block
`timescale 1ns/1ps
`include "rps_map.vh"
module rps_sva
#(
  parameter OUT_PINS = 10
)
(
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   clk_en,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`RPS_ADDR_W-1:0] paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   uart_receive_in,
  input wire logic                   uart_clear_to_send_in,
  input wire logic                   spi_clock_in,
  input wire logic                   spi_data_in,
  input wire logic                   spi_slave_select_in,
  input wire logic [OUT_PINS-1:0]    pin_out_en,
  input wire logic                   selectors_locked
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_TAKE: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("no answer after taken access");
  AST_PULSE: assert property (pready && clk_en |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  // Reset checks run during reset itself, so the default disable is lifted
  AST_RST_LOCK: assert property (disable iff (1'b0) reset |=> selectors_locked)
    else $error("not locked after reset");
  AST_RST_IN: assert property (disable iff (1'b0) reset |=> !(uart_receive_in
    | uart_clear_to_send_in | spi_clock_in | spi_data_in | spi_slave_select_in))
    else $error("peripheral input not grounded after reset");
  AST_RST_OUT: assert property (disable iff (1'b0) reset |=> pin_out_en == 0)
    else $error("pin driven after reset");
  // Lock register holds bit 6, so only selector offsets are checked
  AST_RD_ZERO: assert property (pready && !pwrite && paddr < `RPS_OFF_LOCK
    |-> prdata[31:13] == 0 && prdata[7:5] == 0)
    else $error("unfielded bits read nonzero");
  AST_SS_HI: assert property (pready && !pwrite && paddr == `RPS_OFF_SPI_SS_IN
    |-> prdata[31:5] == 0)
    else $error("select register upper bits nonzero");
  AST_LOCK_HOLD: assert property (!psel |=> $stable(selectors_locked))
    else $error("lock moved without bus access");
endmodule // rps_sva
bind rps_top rps_sva #(.OUT_PINS(OUT_PINS)) u_sva (.clk_sys, .reset, .clk_en, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .uart_receive_in,
  .uart_clear_to_send_in, .spi_clock_in, .spi_data_in, .spi_slave_select_in,
  .pin_out_en, .selectors_locked);

// ===== bench/rps_top_tb.sv
// Self-checking bench of the pin select block
`timescale 1ns/1ps
`include "rps_map.vh"
module rps_top_tb;
  reg         clk_sys = 1'h0;
  reg         reset   = 1'h1;
  reg         clk_en  = 1'h1;
  reg         psel    = 1'h0;
  reg         penable = 1'h0;
  reg         pwrite  = 1'h0;
  reg  [11:0] paddr   = 12'h0;
  reg  [31:0] pwdata  = 32'h0;
  reg  [31:0] seed_v  = 32'h0;
  reg  [31:0] rd, wv;
  reg         er;
  reg  [4:0]  cd [0:4];
  reg  [4:0]  fl, fh;
  integer     fails = 0, check_count = 0, i, n;
  wire [31:0] prdata;
  wire        pready, pslverr, tx, rts, rx_w, cts_w, sck_w, sdi_w, ss_w, lk;
  wire [25:0] pins;
  wire [9:0]  port_v, pin_out, pin_out_en;
  // Function codes under test: none, transmit, request-to-send, unknown
  reg  [4:0]  ftab [0:3] = '{5'h00, 5'h03, 5'h04, 5'h07};
  always #4 clk_sys = ~clk_sys;
  rps_periph u_per (.clk_sys(clk_sys), .seed_v(seed_v), .pins(pins), .tx(tx), .rts(rts),
    .port_v(port_v));
  rps_top uut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .remappable_pin(pins), .uart_transmit_out(tx),
    .uart_rts_out(rts), .port_out(port_v), .pin_out(pin_out), .pin_out_en(pin_out_en),
    .uart_receive_in(rx_w), .uart_clear_to_send_in(cts_w), .spi_clock_in(sck_w),
    .spi_data_in(sdi_w), .spi_slave_select_in(ss_w), .selectors_locked(lk));
  // Pin n for codes up to 25, ground otherwise
  function route(input [4:0] c, input [25:0] p);
    route = (c <= 5'h19) ? p[c] : 1'h0;
  endfunction
  // Pin value expected for a function code
  function pval(input [4:0] f, input t, input r, input pv);
    pval = (f == 5'h03) ? t : (f == 5'h04) ? r : pv;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is seen at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    // No cycle count assumed: only the watchdog ends a wait
    do @(posedge clk_sys); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  // Key sequence, then lock bit write
  task key(input [31:0] last);
    apb(1'h1, `RPS_OFF_OSC_LOW, 32'h46);
    apb(1'h1, `RPS_OFF_OSC_LOW, 32'h57);
    apb(1'h1, `RPS_OFF_OSC_LOW, last);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    #400000;
    fails = fails + 1;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(32'h44E1));
    repeat (6) @(posedge clk_sys);
    reset <= 1'h0;
    for (i = 0; i < 8; i = i + 1)
    begin
      apb(1'h0, 12'(i * 4), 32'h0);
      chk(rd, (i < 2) ? 32'h1F1F : (i == 2) ? 32'h1F : 32'h0);
    end
    apb(1'h1, `RPS_OFF_UART_IN, 32'h0);
    apb(1'h0, `RPS_OFF_UART_IN, 32'h0);
    chk(rd, 32'h1F1F);
    key(32'h0);
    // Lock status shows one cycle after the write lands
    @(posedge clk_sys);
    chk(lk, 1'h0);
    for (i = 0; i < 8; i = i + 1)
    begin
      apb(1'h1, 12'(i * 4), 32'hFFFFFFFF);
      apb(1'h0, 12'(i * 4), 32'h0);
      chk(rd, (i == 2) ? 32'h1F : 32'h1F1F);
    end
    apb(1'h0, 12'h040, 32'h0);
    chk(er, 1'h1);
    // Input routing, boundary codes first then random
    for (i = 0; i < 30; i = i + 1)
    begin
      for (n = 0; n < 5; n = n + 1)
        cd[n] = (i == 0) ? 5'h00 : (i == 1) ? 5'h19 : (i == 2) ? 5'h1F : 5'($urandom % 26);
      apb(1'h1, `RPS_OFF_UART_IN, {19'h0, cd[1], 3'h0, cd[0]});
      apb(1'h1, `RPS_OFF_SPI_CD_IN, {19'h0, cd[2], 3'h0, cd[3]});
      apb(1'h1, `RPS_OFF_SPI_SS_IN, {27'h0, cd[4]});
      seed_v <= $urandom;
      repeat (3) @(posedge clk_sys);
      chk(rx_w, route(cd[0], pins));
      chk(cts_w, route(cd[1], pins));
      chk(sck_w, route(cd[2], pins));
      chk(sdi_w, route(cd[3], pins));
      chk(ss_w, route(cd[4], pins));
    end
    // Clock enable low: routed inputs hold although every pin flips
    wv = {27'h0, rx_w, cts_w, sck_w, sdi_w, ss_w};
    clk_en <= 1'h0;
    seed_v <= ~seed_v;
    repeat (3) @(posedge clk_sys);
    chk({27'h0, rx_w, cts_w, sck_w, sdi_w, ss_w}, wv);
    clk_en <= 1'h1;
    // Output routing over all five pair registers
    for (i = 0; i < 5; i = i + 1)
    begin
      fl = ftab[i % 4];
      fh = ftab[(i + 1) % 4];
      apb(1'h1, 12'(`RPS_OFF_OUT_0_1 + i * 4), {19'h0, fh, 3'h0, fl});
      seed_v <= $urandom;
      repeat (3) @(posedge clk_sys);
      chk(pin_out_en[2 * i], fl == 5'h03 || fl == 5'h04);
      chk(pin_out_en[2 * i + 1], fh == 5'h03 || fh == 5'h04);
      if (fl != 5'h07)
        chk(pin_out[2 * i], pval(fl, tx, rts, port_v[2 * i]));
      if (fh != 5'h07)
        chk(pin_out[2 * i + 1], pval(fh, tx, rts, port_v[2 * i + 1]));
    end
    key(32'h40);
    @(posedge clk_sys);
    chk(lk, 1'h1);
    apb(1'h1, `RPS_OFF_OUT_0_1, 32'h0);
    apb(1'h0, `RPS_OFF_OUT_0_1, 32'h0);
    chk(rd, 32'h0300);
    tally_and_finish;
  end
endmodule // rps_top_tb
